/* File: core/dac_ctl_dev.sv */
// converter end: clear, default value, ramp and fault alarm logic
// Operation
// - alarm when output drive headroom is low
// - alarm when core temperature is too high
// - alarm pin is open-drain, active low
// - status shows loop fault and thermal flags
// - clear input high forces cleared output level
// - clear level is pin OR control bit
// - cleared voltage code depends on range, choice
// - current output clears to range bottom
// - host holds clear for the minimum time
// - output stays cleared after clear falls
// - bare latch pulse restores the preclear value
// - no new value accepted while clear high
// - range change drives the default value
// - host disables output before range change
// - output enable rising drives the default value
// - span extend bit widens voltage span
// - outside resistor bit selects external resistor
// - loop signal passes only while output enabled
// - host enables ramp limiting when loop signalling
// - span field picks range and active output
// - clear under ramp limit ramps, not steps
`timescale 1ns/1ps
module dac_ctl_dev
  import dac_ctl_pkg::*;
#(
  parameter int unsigned CODE_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  dac_ctl_if.dev pins,
  input wire logic i_headroom_low,
  input wire logic i_over_temp,
  output logic [CODE_W-1:0] o_code,
  output logic o_vout_on,
  output logic o_iout_on,
  output logic o_span_extend,
  output logic o_outside_res,
  output logic o_loop_signal_pass,
  output logic [2:0] o_span
);
  import dac_ctl_pkg::*;

  logic [15:0] ctrl_ff;
  logic [15:0] pend_data_ff;
  logic pend_ctrl_ff;
  logic pending_ff;
  logic latch_n_ff;
  logic cleared_ff;
  logic [CODE_W-1:0] target_ff;
  logic [CODE_W-1:0] preclear_ff;
  logic [CODE_W-1:0] out_ff;
  logic [11:0] div_ff;
  logic fault_ff;
  logic [2:0] status_ff;

  logic latch_fall;
  logic eff_sel;
  logic is_current;
  logic [CODE_W-1:0] default_code;
  logic [CODE_W-1:0] step;
  logic [11:0] div_top;
  logic tick;

  // ************************************************************
  // decode
  // ************************************************************
  assign latch_fall = latch_n_ff && !pins.latch_n;
  assign eff_sel = pins.clear_sel | ctrl_ff[CW_ZERO_OR_MID];
  assign is_current = ctrl_ff[CW_SPAN_HI];

  always_comb begin
    if (is_current) begin
      default_code = CODE_ZERO[CODE_W-1:0];
    end else if (ctrl_ff[1:0] == SPAN_V_0_5[1:0] || ctrl_ff[1:0] == SPAN_V_0_10[1:0]) begin
      default_code = eff_sel ? CODE_MID[CODE_W-1:0] : CODE_ZERO[CODE_W-1:0];
    end else begin
      // bipolar ranges are offset binary, so 0 V sits at midscale
      default_code = eff_sel ? CODE_ZERO[CODE_W-1:0] : CODE_MID[CODE_W-1:0];
    end
  end

  assign step = CODE_W'(1) << ctrl_ff[CW_RSTEP_HI:CW_RSTEP_LO];
  assign div_top = 12'((ctrl_ff[CW_RCLK_HI:CW_RCLK_LO] + 1) * RAMP_BASE_DIV - 1);
  assign tick = (div_ff == div_top);

  // ************************************************************
  // pending write from the host
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending_ff <= 1'b0;
      pend_ctrl_ff <= 1'b0;
      pend_data_ff <= 16'h0000;
    end else if (pins.load && !pins.clear) begin
      pending_ff <= 1'b1;
      pend_ctrl_ff <= pins.load_ctrl;
      pend_data_ff <= pins.load_data;
    end else if (latch_fall) begin
      pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_n_ff <= 1'b1;
    end else begin
      latch_n_ff <= pins.latch_n;
    end
  end

  // ************************************************************
  // control word and target code
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff <= CW_RESET;
    end else if (latch_fall && pending_ff && pend_ctrl_ff && !pins.clear) begin
      ctrl_ff <= pend_data_ff;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      target_ff <= CODE_ZERO[CODE_W-1:0];
      preclear_ff <= CODE_ZERO[CODE_W-1:0];
      cleared_ff <= 1'b0;
    end else if (pins.clear) begin
      // remember the live value once, then hold the clear level
      if (!cleared_ff) begin
        preclear_ff <= target_ff;
      end
      cleared_ff <= 1'b1;
      target_ff <= default_code;
    end else if (latch_fall && pending_ff) begin
      cleared_ff <= 1'b0;
      if (!pend_ctrl_ff) begin
        target_ff <= pend_data_ff[15 -: CODE_W];
      end else if (pend_data_ff[CW_SPAN_HI:0] != ctrl_ff[CW_SPAN_HI:0] ||
                   (pend_data_ff[CW_DRIVE_ON] && !ctrl_ff[CW_DRIVE_ON])) begin
        // new control word is not yet in ctrl_ff, so derive its default here
        if (pend_data_ff[CW_SPAN_HI]) begin
          target_ff <= CODE_ZERO[CODE_W-1:0];
        end else if (!pend_data_ff[1]) begin
          target_ff <= (pins.clear_sel | pend_data_ff[CW_ZERO_OR_MID]) ?
                       CODE_MID[CODE_W-1:0] : CODE_ZERO[CODE_W-1:0];
        end else begin
          target_ff <= (pins.clear_sel | pend_data_ff[CW_ZERO_OR_MID]) ?
                       CODE_ZERO[CODE_W-1:0] : CODE_MID[CODE_W-1:0];
        end
      end
    end else if (latch_fall && cleared_ff) begin
      target_ff <= preclear_ff;
      cleared_ff <= 1'b0;
    end
  end

  // ************************************************************
  // output code, stepped when ramp limiting is on
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_ff <= 12'h000;
    end else if (!ctrl_ff[CW_RAMP_ON] || tick) begin
      div_ff <= 12'h000;
    end else begin
      div_ff <= div_ff + 12'h001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_ff <= CODE_ZERO[CODE_W-1:0];
    end else if (!ctrl_ff[CW_RAMP_ON]) begin
      out_ff <= target_ff;
    end else if (tick) begin
      // ramps apply to clears too, so no step straight to the clear level
      if (target_ff > out_ff) begin
        out_ff <= (target_ff - out_ff > step) ? out_ff + step : target_ff;
      end else if (target_ff < out_ff) begin
        out_ff <= (out_ff - target_ff > step) ? out_ff - step : target_ff;
      end
    end
  end

  // ************************************************************
  // alarm and status
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_ff <= 1'b0;
      status_ff <= 3'h0;
    end else begin
      fault_ff <= i_headroom_low | i_over_temp;
      status_ff[ST_IOUT_FAULT] <= i_headroom_low;
      status_ff[ST_HOT] <= i_over_temp;
      status_ff[ST_RAMP_BUSY] <= ctrl_ff[CW_RAMP_ON] && (out_ff != target_ff);
    end
  end

  // output level is always low; only the enable moves
  assign pins.fault_n_o = 1'b0;
  assign pins.fault_n_oe = fault_ff;
  assign pins.status = status_ff;

  // ************************************************************
  // analog steering
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_code <= CODE_ZERO[CODE_W-1:0];
      o_vout_on <= 1'b0;
      o_iout_on <= 1'b0;
      o_span_extend <= 1'b0;
      o_outside_res <= 1'b0;
      o_loop_signal_pass <= 1'b0;
      o_span <= 3'h0;
    end else begin
      o_code <= out_ff;
      o_vout_on <= ctrl_ff[CW_DRIVE_ON] && !is_current;
      o_iout_on <= ctrl_ff[CW_DRIVE_ON] && is_current;
      o_span_extend <= ctrl_ff[CW_SPAN_EXTEND] && !is_current;
      o_outside_res <= ctrl_ff[CW_OUTSIDE_RES];
      o_loop_signal_pass <= ctrl_ff[CW_DRIVE_ON] && is_current;
      o_span <= ctrl_ff[CW_SPAN_HI:0];
    end
  end
endmodule : dac_ctl_dev

/* File: core/dac_ctl_pkg.sv */
// shared constants for the converter clear and fault control ends
package dac_ctl_pkg;
  // ************************************************************
  // control word field positions
  // ************************************************************
  localparam int unsigned CW_WIDTH = 16;
  localparam int unsigned CW_ZERO_OR_MID = 15;
  localparam int unsigned CW_SPAN_EXTEND = 14;
  localparam int unsigned CW_OUTSIDE_RES = 13;
  localparam int unsigned CW_DRIVE_ON = 12;
  localparam int unsigned CW_RCLK_HI = 11;
  localparam int unsigned CW_RCLK_LO = 8;
  localparam int unsigned CW_RSTEP_HI = 7;
  localparam int unsigned CW_RSTEP_LO = 5;
  localparam int unsigned CW_RAMP_ON = 4;
  localparam int unsigned CW_SPAN_HI = 2;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // ************************************************************
  // span choices and codes
  // ************************************************************
  localparam logic [2:0] SPAN_V_0_5 = 3'h0;
  localparam logic [2:0] SPAN_V_0_10 = 3'h1;
  localparam logic [2:0] SPAN_V_PM5 = 3'h2;
  localparam logic [2:0] SPAN_V_PM10 = 3'h3;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  // ************************************************************
  // status bit positions
  // ************************************************************
  localparam int unsigned ST_IOUT_FAULT = 2;
  localparam int unsigned ST_RAMP_BUSY = 1;
  localparam int unsigned ST_HOT = 0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned CLEAR_MIN_NS = 50;
  localparam int unsigned LATCH_MIN_NS = 20;
  localparam int unsigned CLEAR_MIN_CYC = (CLEAR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LATCH_MIN_CYC = (LATCH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RAMP_BASE_DIV = 16;
endpackage : dac_ctl_pkg

/* File: core/dac_ctl_if.sv */
// pin bundle joining the host controller and the converter control block
`timescale 1ns/1ps
interface dac_ctl_if;
  logic clear;
  logic clear_sel;
  logic latch_n;
  logic load;
  logic load_ctrl;
  logic [15:0] load_data;
  logic fault_n_o;
  logic fault_n_oe;
  logic fault_n;
  logic [2:0] status;
  // open drain with pull-up
  assign fault_n = fault_n_oe ? fault_n_o : 1'b1;
  modport dev (input clear, input clear_sel, input latch_n, input load, input load_ctrl,
               input load_data, output fault_n_o, output fault_n_oe, output status);
  modport host (output clear, output clear_sel, output latch_n, output load, output load_ctrl,
                output load_data, input fault_n, input status);
endinterface : dac_ctl_if

/* File: core/dac_ctl_host.sv */
// host end: drives clear, clear level pin, loads and latch strobe
`timescale 1ns/1ps
module dac_ctl_host
  import dac_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  dac_ctl_if.host pins,
  input wire logic i_clear,
  input wire logic i_clear_sel,
  input wire logic i_loop_signal_use,
  input wire logic i_wr_valid,
  input wire logic i_wr_ctrl,
  input wire logic [15:0] i_wr_data,
  input wire logic i_restore,
  output logic o_ready,
  output logic o_fault,
  output logic [2:0] o_status
);
  import dac_ctl_pkg::*;

  typedef enum logic [1:0] {IDLE = 2'b00, LOAD = 2'b01, LATCH = 2'b11, GAP = 2'b10} state_t;
  state_t state_ff;
  logic [15:0] word_ff;
  logic word_ctrl_ff;
  logic bare_ff;
  logic second_ff;
  logic [15:0] last_ctrl_ff;
  logic [15:0] queued_ff;
  logic [7:0] cnt_ff;
  logic [7:0] clr_cnt_ff;
  logic clear_ff;
  logic clr_sel_ff;
  logic load_ff;
  logic latch_n_ff;
  logic [15:0] req_ctrl;

  // ramp limiting forced on while loop signalling is in use
  assign req_ctrl = i_wr_data | (i_loop_signal_use ? (16'h0001 << CW_RAMP_ON) : 16'h0000);

  // ************************************************************
  // clear held for its minimum width
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clear_ff <= 1'b0;
      clr_cnt_ff <= 8'h00;
      clr_sel_ff <= 1'b0;
    end else begin
      clr_sel_ff <= i_clear_sel;
      if (i_clear && !clear_ff) begin
        clear_ff <= 1'b1;
        clr_cnt_ff <= 8'(CLEAR_MIN_CYC - 1);
      end else if (clr_cnt_ff != 8'h00) begin
        clr_cnt_ff <= clr_cnt_ff - 8'h01;
      end else if (!i_clear) begin
        clear_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // write and latch sequencer
  // ************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= IDLE;
      word_ff <= 16'h0000;
      word_ctrl_ff <= 1'b0;
      bare_ff <= 1'b0;
      second_ff <= 1'b0;
      queued_ff <= 16'h0000;
      last_ctrl_ff <= CW_RESET;
      cnt_ff <= 8'h00;
      load_ff <= 1'b0;
      latch_n_ff <= 1'b1;
    end else begin
      load_ff <= 1'b0;
      case (state_ff)
        IDLE: begin
          if (!clear_ff && i_wr_valid) begin
            word_ctrl_ff <= i_wr_ctrl;
            bare_ff <= 1'b0;
            if (i_wr_ctrl && last_ctrl_ff[CW_DRIVE_ON] &&
                req_ctrl[CW_SPAN_HI:0] != last_ctrl_ff[CW_SPAN_HI:0]) begin
              // switch the output off before a range change
              word_ff <= last_ctrl_ff & ~(16'h0001 << CW_DRIVE_ON);
              queued_ff <= req_ctrl;
              second_ff <= 1'b1;
            end else begin
              word_ff <= i_wr_ctrl ? req_ctrl : i_wr_data;
              second_ff <= 1'b0;
            end
            state_ff <= LOAD;
          end else if (!clear_ff && i_restore) begin
            bare_ff <= 1'b1;
            latch_n_ff <= 1'b0;
            cnt_ff <= 8'(LATCH_MIN_CYC - 1);
            state_ff <= LATCH;
          end
        end
        LOAD: begin
          load_ff <= 1'b1;
          if (word_ctrl_ff) begin
            last_ctrl_ff <= word_ff;
          end
          // strobe falls one cycle after the load so the converter already holds the word as pending
          cnt_ff <= 8'(LATCH_MIN_CYC);
          state_ff <= LATCH;
        end
        LATCH: begin
          if (cnt_ff == 8'h00) begin
            latch_n_ff <= 1'b1;
            state_ff <= GAP;
          end else begin
            latch_n_ff <= 1'b0;
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        GAP: begin
          if (second_ff) begin
            second_ff <= 1'b0;
            word_ff <= queued_ff;
            state_ff <= LOAD;
          end else begin
            state_ff <= IDLE;
          end
        end
        default: begin
          state_ff <= IDLE;
        end
      endcase
    end
  end

  assign pins.clear = clear_ff;
  assign pins.clear_sel = clr_sel_ff;
  assign pins.load = load_ff;
  assign pins.load_ctrl = word_ctrl_ff;
  assign pins.load_data = word_ff;
  assign pins.latch_n = latch_n_ff;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_fault <= 1'b0;
      o_status <= 3'h0;
    end else begin
      o_ready <= (state_ff == IDLE) && !clear_ff && !i_wr_valid && !i_restore;
      o_fault <= !pins.fault_n;
      o_status <= pins.status;
    end
  end
endmodule : dac_ctl_host

/* File: verif/dac_ctl_asserts.sv */
// concurrent checks on the link between the host end and the converter end
`timescale 1ns/1ps
module dac_ctl_asserts
  import dac_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic clear,
  input wire logic latch_n,
  input wire logic load,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  input wire logic fault_n,
  input wire logic [2:0] status,
  input wire logic i_headroom_low,
  input wire logic i_over_temp
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ************************************************************
  // alarm pin and status flags
  // ************************************************************
  a_alarm_on_headroom: assert property (i_headroom_low |=> !fault_n)
    else $error("alarm pin not low after headroom loss");
  a_alarm_on_heat: assert property (i_over_temp |=> !fault_n)
    else $error("alarm pin not low after over temperature");
  a_alarm_pulls_low: assert property (fault_n_oe |-> fault_n_o == 1'b0)
    else $error("alarm driver drives a high level");
  a_loop_flag_follows: assert property (1'b1 |=> status[ST_IOUT_FAULT] == $past(i_headroom_low))
    else $error("loop fault flag does not track its cause");
  a_hot_flag_follows: assert property (1'b1 |=> status[ST_HOT] == $past(i_over_temp))
    else $error("thermal flag does not track its cause");
  a_alarm_release: assert property (!i_headroom_low && !i_over_temp |=> fault_n)
    else $error("alarm pin held with no cause");
  // ************************************************************
  // host side pin discipline
  // ************************************************************
  a_no_load_in_clear: assert property (load |-> !clear)
    else $error("word loaded while clear is high");
  a_clear_min_width: assert property ($rose(clear) |-> clear [*5])
    else $error("clear pulse shorter than minimum");
  a_latch_low_width: assert property ($fell(latch_n) |-> !latch_n [*2])
    else $error("latch strobe shorter than minimum");
  c_clear_seen: cover property ($rose(clear));
  c_alarm_seen: cover property (!fault_n);
  c_latch_seen: cover property ($fell(latch_n) && !clear);
  c_ramp_seen: cover property (status[ST_RAMP_BUSY]);
endmodule : dac_ctl_asserts

/* File: verif/tb.sv */
// self-checking bench joining both ends of the converter control link
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); \
  end \
end
module tb;
  import dac_ctl_pkg::*;
  logic i_sys_clk, i_rst_n, i_headroom_low, i_over_temp;
  logic i_clear, i_clear_sel, i_loop_signal_use, i_wr_valid, i_wr_ctrl, i_restore;
  logic [15:0] i_wr_data, o_code;
  logic o_vout_on, o_iout_on, o_span_extend, o_outside_res, o_loop_signal_pass, o_ready, o_fault;
  logic [2:0] o_span, o_status, s;
  logic [2:0] spans [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  int miscompares = 0;
  int checks_done = 0;
  dac_ctl_if dac_ctl_if_i ();
  dac_ctl_dev dac_ctl_dev_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .pins(dac_ctl_if_i),
    .i_headroom_low(i_headroom_low), .i_over_temp(i_over_temp), .o_code(o_code), .o_vout_on(o_vout_on),
    .o_iout_on(o_iout_on), .o_span_extend(o_span_extend), .o_outside_res(o_outside_res),
    .o_loop_signal_pass(o_loop_signal_pass), .o_span(o_span));
  dac_ctl_host dac_ctl_host_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .pins(dac_ctl_if_i),
    .i_clear(i_clear), .i_clear_sel(i_clear_sel), .i_loop_signal_use(i_loop_signal_use),
    .i_wr_valid(i_wr_valid), .i_wr_ctrl(i_wr_ctrl), .i_wr_data(i_wr_data), .i_restore(i_restore),
    .o_ready(o_ready), .o_fault(o_fault), .o_status(o_status));
  dac_ctl_asserts dac_ctl_asserts_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .clear(dac_ctl_if_i.clear),
    .latch_n(dac_ctl_if_i.latch_n), .load(dac_ctl_if_i.load), .fault_n_o(dac_ctl_if_i.fault_n_o),
    .fault_n_oe(dac_ctl_if_i.fault_n_oe), .fault_n(dac_ctl_if_i.fault_n), .status(dac_ctl_if_i.status),
    .i_headroom_low(i_headroom_low), .i_over_temp(i_over_temp));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] dflt(input logic [2:0] sp, input logic sel);
    if (sp[2]) return CODE_ZERO;
    if (sp[1]) return sel ? CODE_ZERO : CODE_MID;
    return sel ? CODE_MID : CODE_ZERO;
  endfunction : dflt
  function automatic logic [15:0] cw(input logic sel, ext, res, on, input logic [2:0] step, input logic sp2,
                                     input logic [2:0] sp);
    return {sel, ext, res, on, 4'h0, step, sp2, 1'b0, sp};
  endfunction : cw
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc
  // ready is a level; a bounded poll keeps a stuck host from hanging the run
  task automatic wait_ready(input logic v);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (o_ready !== v && n < 60);
    `CHK("ready", v, o_ready)
  endtask : wait_ready
  task automatic wr(input logic c, input logic [15:0] d, input logic r);
    @(posedge i_sys_clk);
    i_wr_ctrl <= c;
    i_wr_data <= d;
    i_wr_valid <= !r;
    i_restore <= r;
    wait_ready(1'b0);
    @(posedge i_sys_clk);
    i_wr_valid <= 1'b0;
    i_restore <= 1'b0;
    wait_ready(1'b1);
    cyc(4);
  endtask : wr
  task automatic clr();
    @(posedge i_sys_clk);
    i_clear <= 1'b1;
    @(posedge i_sys_clk);
    i_clear <= 1'b0;
    cyc(12);
  endtask : clr
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // ************************************************************
  // clock, watchdog and tests
  // ************************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_of_test();
  end
  initial begin
    {i_rst_n, i_headroom_low, i_over_temp, i_clear, i_clear_sel} = '0;
    {i_loop_signal_use, i_wr_valid, i_wr_ctrl, i_restore} = '0;
    i_wr_data = 16'h0000;
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    cyc(2);
    `CHK("code", CODE_ZERO, o_code)
    `CHK("alarm pin", 1'b1, dac_ctl_if_i.fault_n)
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 7; j++) begin
        s = spans[j];
        @(posedge i_sys_clk);
        i_clear_sel <= (k == 2);
        wr(1'b0, 16'h1234, 1'b0);
        `CHK("data code", 16'h1234, o_code)
        wr(1'b1, cw(k == 1, j[0], k[0], 1'b1, 3'h0, 1'b0, s), 1'b0);
        `CHK("default code", dflt(s, k != 0), o_code)
        `CHK("span", s, o_span)
        `CHK("voltage on", ~s[2], o_vout_on)
        `CHK("current on", s[2], o_iout_on)
        `CHK("span extend", j[0] & ~s[2], o_span_extend)
        `CHK("outside res", k[0], o_outside_res)
      end
    end
    wr(1'b1, cw(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 3'h1), 1'b0);
    wr(1'b0, 16'hABCD, 1'b0);
    `CHK("voltage off", 1'b0, o_vout_on)
    wr(1'b1, cw(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 3'h1), 1'b0);
    `CHK("enable default", CODE_MID, o_code)
    $display("test spans done");
    wr(1'b0, 16'hABCD, 1'b0);
    clr();
    `CHK("cleared code", CODE_MID, o_code)
    cyc(20);
    `CHK("clear held", CODE_MID, o_code)
    wr(1'b0, 16'h0000, 1'b1);
    `CHK("restored code", 16'hABCD, o_code)
    @(posedge i_sys_clk);
    i_clear_sel <= 1'b0;
    wr(1'b1, cw(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 3'h3), 1'b0);
    wr(1'b0, 16'h1111, 1'b0);
    clr();
    `CHK("bipolar clear", CODE_MID, o_code)
    @(posedge i_sys_clk);
    i_clear_sel <= 1'b1;
    clr();
    `CHK("bipolar clear sel", CODE_ZERO, o_code)
    $display("test clear done");
    @(posedge i_sys_clk);
    i_loop_signal_use <= 1'b1;
    wr(1'b1, cw(1'b0, 1'b0, 1'b0, 1'b1, 3'h7, 1'b0, 3'h5), 1'b0);
    `CHK("loop pass on", 1'b1, o_loop_signal_pass)
    wr(1'b0, 16'h0400, 1'b0);
    `CHK("ramp busy", 1'b1, o_status[ST_RAMP_BUSY])
    cyc(200);
    `CHK("ramp end", 16'h0400, o_code)
    clr();
    `CHK("clear stepped", 1'b0, o_code == CODE_ZERO)
    cyc(200);
    `CHK("current bottom", CODE_ZERO, o_code)
    wr(1'b1, cw(1'b0, 1'b0, 1'b0, 1'b0, 3'h7, 1'b0, 3'h5), 1'b0);
    `CHK("loop pass off", 1'b0, o_loop_signal_pass)
    $display("test ramp done");
    for (int a = 1; a < 5; a++) begin
      @(posedge i_sys_clk);
      i_headroom_low <= a[0];
      i_over_temp <= a[1];
      cyc(4);
      `CHK("alarm pin", ~(a[0] | a[1]), dac_ctl_if_i.fault_n)
      `CHK("alarm out", a[0] | a[1], o_fault)
      `CHK("loop flag", a[0], o_status[ST_IOUT_FAULT])
      `CHK("hot flag", a[1], o_status[ST_HOT])
    end
    $display("test alarm done");
    end_of_test();
  end
endmodule : tb
